// *** ufm_uart.sv ***
// Purpose: Serial port with FIFOs, line control, modem control and line status behind Avalon-MM.
// Assumes: All inputs synchronous to clk_in; serial_in idles high.
// Notes: Every access has one wait state; read side effects happen at the completing edge.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "ufm_defs.svh"

module ufm_uart #(
    parameter int FIFO_DEPTH = 16,
    parameter int CNT_W = 5
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic clear_to_send_in_n,
    input wire logic set_ready_in_n,
    input wire logic ring_in_n,
    input wire logic carrier_in_n,
    output logic terminal_ready_out_n,
    output logic send_request_out_n,
    output logic irq_out,
    output logic irq_oe_n_out
);
    import ufm_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);

    // Masks a character down to the selected word length.
    function automatic logic [7:0] mask_len(input logic [7:0] d, input logic [1:0] wl);
        mask_len = d & (8'hFF >> (3'h3 - {1'b0, wl}));
    endfunction

    // Parity bit value for a character under the current line format.
    function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
        if (lc[`UFM_LC_STICK]) begin
            par_bit = ~lc[`UFM_LC_EPS];
        end else begin
            par_bit = (^mask_len(d, lc[1:0])) ^ ~lc[`UFM_LC_EPS];
        end
    endfunction

    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] lcr_q;
    logic [7:0] mcr_q;
    logic [7:0] ier_q;
    logic [7:0] scr_q;
    logic [15:0] div_q;
    logic [15:0] bcnt_q;
    logic fifo_en_q;
    logic [1:0] trig_q;
    logic oe_q;
    logic pe_q;
    logic fe_q;
    logic thri_q;
    logic thre_prev_q;
    logic [3:0] mstat_q;
    logic [3:0] mdelta_q;
    logic [9:0] rx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] rx_wr_q;
    logic [PTR_W-1:0] rx_rd_q;
    logic [CNT_W-1:0] rx_cnt_q;
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] tx_wr_q;
    logic [PTR_W-1:0] tx_rd_q;
    logic [CNT_W-1:0] tx_cnt_q;
    ufm_line_state_type rx_st_q;
    ufm_line_state_type tx_st_q;
    logic [4:0] rx_tk_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_pe_q;
    logic [4:0] tx_tk_q;
    logic [2:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic tx_line_q;

    logic req;
    logic acc;
    logic [2:0] idx;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wd;
    logic divisor_latch_access_bit;
    logic loop;
    logic tick;
    logic rx_line;
    logic fc_wr;
    logic rx_flush;
    logic tx_flush;
    logic rx_push;
    logic [9:0] rx_new;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic [CNT_W-1:0] cap;
    logic rx_full;
    logic tx_full;
    logic head_new;
    logic [9:0] head_val;
    logic [CNT_W-1:0] trig_lvl;
    logic thre;
    logic temt;
    logic [3:0] mnow;
    logic [7:0] line_status;
    logic [2:0] iid;
    logic [7:0] rval;

    // Bus decode; a request is accepted on the second cycle it is held.
    assign req = avs_read_in | avs_write_in;
    assign acc = req & ack_q;
    assign idx = avs_address_in[4:2];
    assign wd = avs_writedata_in[7:0];
    assign wr_acc = acc & avs_write_in & avs_byteenable_in[0];
    assign rd_acc = acc & avs_read_in;
    assign divisor_latch_access_bit = lcr_q[`UFM_LC_DIVISOR_LATCH_ACCESS_BIT];
    assign loop = mcr_q[`UFM_MC_LOOP];
    assign avs_waitrequest_out = req & ~ack_q;
    assign avs_readdata_out = rdata_q;

    // Write to the FIFO control location; a zero enable bit flushes both FIFOs.
    assign fc_wr = wr_acc & (idx == `UFM_IDX_FIFO);
    assign rx_flush = fc_wr & (~wd[`UFM_FC_EN] | wd[`UFM_FC_RXFL]);
    assign tx_flush = fc_wr & (~wd[`UFM_FC_EN] | wd[`UFM_FC_TXFL]);

    // Without FIFOs each direction holds a single character.
    assign cap = fifo_en_q ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
    assign rx_full = rx_cnt_q >= cap;
    assign tx_full = tx_cnt_q >= cap;
    assign rx_pop = rd_acc & (idx == `UFM_IDX_DATA) & ~divisor_latch_access_bit & (rx_cnt_q != '0);
    assign tx_push = wr_acc & (idx == `UFM_IDX_DATA) & ~divisor_latch_access_bit & ~tx_full;
    assign tx_pop = (tx_st_q == UFM_IDLE) & tick & (tx_cnt_q != '0);

    // The head changes when a character lands in an empty buffer or an older one leaves.
    assign head_new = (rx_push & (rx_cnt_q == '0 | (rx_full & ~fifo_en_q) | (rx_pop & rx_cnt_q == CNT_W'(1))))
                      | (rx_pop & rx_cnt_q > CNT_W'(1));
    assign head_val = rx_push & ~(rx_pop & rx_cnt_q > CNT_W'(1)) ? rx_new : rx_mem[PTR_W'(rx_rd_q + 1'b1)];

    // Receive trigger level decode.
    always_comb begin
        unique case (trig_q)
            2'h0: trig_lvl = `UFM_TRIG_0;
            2'h1: trig_lvl = `UFM_TRIG_1;
            2'h2: trig_lvl = `UFM_TRIG_2;
            2'h3: trig_lvl = `UFM_TRIG_3;
        endcase
    end

    // Modem status sources swap to control bits in loopback.
    assign mnow = loop ? {mcr_q[`UFM_MC_GATE], mcr_q[`UFM_MC_USER_OUTPUT_ONE], mcr_q[`UFM_MC_DTR], mcr_q[`UFM_MC_RTS]}
                       : {~carrier_in_n, ~ring_in_n, ~set_ready_in_n, ~clear_to_send_in_n};
    assign rx_line = loop ? tx_line_q : serial_in;

    assign thre = tx_cnt_q == '0;
    assign temt = thre & (tx_st_q == UFM_IDLE);
    assign line_status = {1'b0, temt, thre, 1'b0, fe_q, pe_q, oe_q, rx_cnt_q != '0};

    // Interrupt priority: line status, received data, holding empty, modem status.
    always_comb begin
        if (ier_q[2] & (oe_q | pe_q | fe_q)) begin
            iid = `UFM_IIR_LS;
        end else if (ier_q[0] & (fifo_en_q ? rx_cnt_q >= trig_lvl : rx_cnt_q != '0)) begin
            iid = `UFM_IIR_RDA;
        end else if (ier_q[1] & thri_q) begin
            iid = `UFM_IIR_THR;
        end else if (ier_q[3] & (mdelta_q != 4'h0)) begin
            iid = 3'h4;
        end else begin
            iid = `UFM_IIR_NONE;
        end
    end

    // Read value mux; unused upper bits read as zero.
    always_comb begin
        unique case (idx)
            `UFM_IDX_DATA: rval = divisor_latch_access_bit ? div_q[7:0] : rx_mem[rx_rd_q][7:0];
            `UFM_IDX_IER: rval = divisor_latch_access_bit ? div_q[15:8] : ier_q;
            `UFM_IDX_FIFO: rval = {{2{fifo_en_q}}, 3'h0, iid[1:0], iid == `UFM_IIR_NONE};
            `UFM_IDX_LCR: rval = lcr_q;
            `UFM_IDX_MCR: rval = mcr_q & `UFM_MC_MASK;
            `UFM_IDX_LSR: rval = line_status;
            `UFM_IDX_MSR: rval = {mstat_q, mdelta_q};
            `UFM_IDX_SCR: rval = scr_q;
        endcase
    end

    // Bus handshake and read data capture one cycle before completion.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read_in & ~ack_q) begin
                rdata_q <= {24'h0, rval};
            end
        end
    end

    // Software-written control registers.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lcr_q <= `UFM_RST_LCR;
            mcr_q <= 8'h00;
            ier_q <= 8'h00;
            scr_q <= 8'h00;
            div_q <= `UFM_RST_DIV;
            fifo_en_q <= 1'b0;
            trig_q <= 2'h0;
        end else if (wr_acc) begin
            unique case (idx)
                `UFM_IDX_DATA: if (divisor_latch_access_bit) div_q[7:0] <= wd;
                `UFM_IDX_IER: if (divisor_latch_access_bit) div_q[15:8] <= wd; else ier_q <= wd & `UFM_IER_MASK;
                `UFM_IDX_FIFO: begin
                    fifo_en_q <= wd[`UFM_FC_EN];
                    // Trigger is only programmed alongside enable; bit 3 and bits 5:4 are dropped.
                    if (wd[`UFM_FC_EN]) trig_q <= wd[7:6];
                end
                `UFM_IDX_LCR: lcr_q <= wd;
                `UFM_IDX_MCR: mcr_q <= wd & `UFM_MC_MASK;
                `UFM_IDX_LSR: ;
                `UFM_IDX_MSR: ;
                `UFM_IDX_SCR: scr_q <= wd;
            endcase
        end
    end

    // Baud divider: one 16x tick per divisor count; zero behaves as one.
    assign tick = bcnt_q <= 16'h0001;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bcnt_q <= `UFM_RST_DIV;
        end else if (wr_acc & divisor_latch_access_bit & (idx == `UFM_IDX_DATA | idx == `UFM_IDX_IER)) begin
            bcnt_q <= 16'h0000;
        end else begin
            bcnt_q <= tick ? div_q : bcnt_q - 16'h0001;
        end
    end

    // Transmit FIFO storage and pointers.
    always_ff @(posedge clk_in) begin
        if (rst_in | tx_flush) begin
            tx_wr_q <= '0;
            tx_rd_q <= '0;
            tx_cnt_q <= '0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wr_q] <= wd;
                tx_wr_q <= PTR_W'(tx_wr_q + 1'b1);
            end
            if (tx_pop) begin
                tx_rd_q <= PTR_W'(tx_rd_q + 1'b1);
            end
            tx_cnt_q <= CNT_W'(tx_cnt_q + CNT_W'(tx_push) - CNT_W'(tx_pop));
        end
    end

    // Transmit shifter; the flush leaves a character in progress alone.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_st_q <= UFM_IDLE;
            tx_tk_q <= 5'h0;
            tx_bit_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_line_q <= 1'b1;
        end else if (tick) begin
            tx_tk_q <= 5'(tx_tk_q + 1'b1);
            unique case (tx_st_q)
                UFM_IDLE: begin
                    tx_line_q <= 1'b1;
                    if (tx_pop) begin
                        tx_sh_q <= mask_len(tx_mem[tx_rd_q], lcr_q[1:0]);
                        tx_st_q <= UFM_START;
                        tx_line_q <= 1'b0;
                        tx_tk_q <= 5'h0;
                    end
                end
                UFM_START: if (tx_tk_q == `UFM_TICKS_BIT - 5'h1) begin
                    tx_st_q <= UFM_DATA;
                    tx_line_q <= tx_sh_q[0];
                    tx_bit_q <= 3'h0;
                    tx_tk_q <= 5'h0;
                end
                UFM_DATA: if (tx_tk_q == `UFM_TICKS_BIT - 5'h1) begin
                    tx_tk_q <= 5'h0;
                    if (tx_bit_q == {1'b1, lcr_q[1:0]}) begin
                        tx_st_q <= lcr_q[`UFM_LC_PEN] ? UFM_PAR : UFM_STOP;
                        tx_line_q <= lcr_q[`UFM_LC_PEN] ? par_bit(tx_sh_q, lcr_q) : 1'b1;
                    end else begin
                        tx_bit_q <= 3'(tx_bit_q + 1'b1);
                        tx_line_q <= tx_sh_q[3'(tx_bit_q + 1'b1)];
                    end
                end
                UFM_PAR: if (tx_tk_q == `UFM_TICKS_BIT - 5'h1) begin
                    tx_st_q <= UFM_STOP;
                    tx_line_q <= 1'b1;
                    tx_tk_q <= 5'h0;
                end
                UFM_STOP: begin
                    // Stop length: 16 ticks, or 24 for five-bit words, or 32 otherwise.
                    if (tx_tk_q == (~lcr_q[`UFM_LC_STOP] ? `UFM_TICKS_BIT - 5'h1 :
                                    (lcr_q[1:0] == 2'h0 ? `UFM_TICKS_ONEHALF - 5'h1 : 5'(`UFM_TICKS_TWO - 6'h1)))) begin
                        tx_st_q <= UFM_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive shifter; samples at mid-bit and checks only the first stop bit.
    always_ff @(posedge clk_in) begin
        rx_push <= 1'b0;
        if (rst_in) begin
            rx_st_q <= UFM_IDLE;
            rx_tk_q <= 5'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_pe_q <= 1'b0;
            rx_new <= 10'h000;
        end else if (tick) begin
            rx_tk_q <= 5'(rx_tk_q + 1'b1);
            unique case (rx_st_q)
                UFM_IDLE: if (~rx_line) begin
                    rx_st_q <= UFM_START;
                    rx_tk_q <= 5'h0;
                end
                UFM_START: if (rx_tk_q == `UFM_TICKS_HALF - 5'h1) begin
                    rx_st_q <= rx_line ? UFM_IDLE : UFM_DATA;
                    rx_tk_q <= 5'h0;
                    rx_bit_q <= 3'h0;
                    rx_sh_q <= 8'h00;
                    rx_pe_q <= 1'b0;
                end
                UFM_DATA: if (rx_tk_q == `UFM_TICKS_BIT - 5'h1) begin
                    rx_tk_q <= 5'h0;
                    rx_sh_q[rx_bit_q] <= rx_line;
                    rx_bit_q <= 3'(rx_bit_q + 1'b1);
                    if (rx_bit_q == {1'b1, lcr_q[1:0]}) begin
                        rx_st_q <= lcr_q[`UFM_LC_PEN] ? UFM_PAR : UFM_STOP;
                    end
                end
                UFM_PAR: if (rx_tk_q == `UFM_TICKS_BIT - 5'h1) begin
                    rx_tk_q <= 5'h0;
                    rx_pe_q <= rx_line != par_bit(rx_sh_q, lcr_q);
                    rx_st_q <= UFM_STOP;
                end
                UFM_STOP: if (rx_tk_q == `UFM_TICKS_BIT - 5'h1) begin
                    rx_new <= {~rx_line, rx_pe_q, rx_sh_q};
                    rx_push <= 1'b1;
                    rx_st_q <= UFM_IDLE;
                end
            endcase
        end
    end

    // Receive FIFO; when full a FIFO drops the character, a single buffer is overwritten.
    always_ff @(posedge clk_in) begin
        if (rst_in | rx_flush) begin
            rx_wr_q <= '0;
            rx_rd_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            // A read in the same cycle frees a slot, so the new character is kept.
            if (rx_push & (~rx_full | rx_pop)) begin
                rx_mem[rx_wr_q] <= rx_new;
                rx_wr_q <= PTR_W'(rx_wr_q + 1'b1);
            end else if (rx_push & ~fifo_en_q & ~rx_pop) begin
                rx_mem[rx_rd_q] <= rx_new;
            end
            if (rx_pop) begin
                rx_rd_q <= PTR_W'(rx_rd_q + 1'b1);
            end
            rx_cnt_q <= CNT_W'(rx_cnt_q + CNT_W'(rx_push & (~rx_full | rx_pop)) - CNT_W'(rx_pop));
        end
    end

    // Sticky line status flags; a new event wins over the clearing read.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            oe_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
        end else begin
            if (rd_acc & (idx == `UFM_IDX_LSR)) begin
                oe_q <= 1'b0;
                pe_q <= 1'b0;
                fe_q <= 1'b0;
            end
            if (rx_push & rx_full & ~rx_pop) oe_q <= 1'b1;
            if (head_new & head_val[8]) pe_q <= 1'b1;
            if (head_new & head_val[9]) fe_q <= 1'b1;
        end
    end

    // Holding-empty interrupt: set on becoming empty, cleared by a data write or identification read.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            thri_q <= 1'b0;
            thre_prev_q <= 1'b1;
        end else begin
            thre_prev_q <= thre;
            if (tx_push | (rd_acc & (idx == `UFM_IDX_FIFO) & (iid == `UFM_IIR_THR))) thri_q <= 1'b0;
            if ((thre & ~thre_prev_q) | (wr_acc & (idx == `UFM_IDX_IER) & ~divisor_latch_access_bit & wd[1] & thre)) thri_q <= 1'b1;
        end
    end

    // Modem status change detection; ring flags only its trailing edge.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mstat_q <= 4'h0;
            mdelta_q <= 4'h0;
        end else begin
            mstat_q <= mnow;
            if (rd_acc & (idx == `UFM_IDX_MSR)) mdelta_q <= 4'h0;
            if (mnow[0] != mstat_q[0]) mdelta_q[0] <= 1'b1;
            if (mnow[1] != mstat_q[1]) mdelta_q[1] <= 1'b1;
            if (~mnow[2] & mstat_q[2]) mdelta_q[2] <= 1'b1;
            if (mnow[3] != mstat_q[3]) mdelta_q[3] <= 1'b1;
        end
    end

    // Registered pins; loopback parks all but irq_out inactive, break overrides the line.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            serial_out <= 1'b1;
            terminal_ready_out_n <= 1'b1;
            send_request_out_n <= 1'b1;
            irq_out <= 1'b0;
            irq_oe_n_out <= 1'b1;
        end else begin
            serial_out <= lcr_q[`UFM_LC_BREAK] ? 1'b0 : (loop | tx_line_q);
            terminal_ready_out_n <= loop | ~mcr_q[`UFM_MC_DTR];
            send_request_out_n <= loop | ~mcr_q[`UFM_MC_RTS];
            irq_out <= iid != `UFM_IIR_NONE;
            irq_oe_n_out <= ~mcr_q[`UFM_MC_GATE] | loop;
        end
    end

endmodule

// *** ufm_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the serial port core.
// Assumes: Register index is byte address bits 4:2 on the Avalon-MM slave.
// Notes: Behaviour of the core, one line per item:
`ifndef UFM_DEFS_SVH
`define UFM_DEFS_SVH

`define UFM_IDX_DATA 3'h0
`define UFM_IDX_IER 3'h1
`define UFM_IDX_FIFO 3'h2
`define UFM_IDX_LCR 3'h3
`define UFM_IDX_MCR 3'h4
`define UFM_IDX_LSR 3'h5
`define UFM_IDX_MSR 3'h6
`define UFM_IDX_SCR 3'h7

`define UFM_FC_EN 0
`define UFM_FC_RXFL 1
`define UFM_FC_TXFL 2
`define UFM_LC_STOP 2
`define UFM_LC_PEN 3
`define UFM_LC_EPS 4
`define UFM_LC_STICK 5
`define UFM_LC_BREAK 6
`define UFM_LC_DIVISOR_LATCH_ACCESS_BIT 7
`define UFM_MC_DTR 0
`define UFM_MC_RTS 1
`define UFM_MC_USER_OUTPUT_ONE 2
`define UFM_MC_GATE 3
`define UFM_MC_LOOP 4
`define UFM_MC_MASK 8'h1F
`define UFM_IER_MASK 8'h0F

`define UFM_TRIG_0 5'h01
`define UFM_TRIG_1 5'h04
`define UFM_TRIG_2 5'h08
`define UFM_TRIG_3 5'h0E

`define UFM_RST_LCR 8'h03
`define UFM_RST_DIV 16'h0001
`define UFM_IIR_NONE 3'h0
`define UFM_IIR_LS 3'h3
`define UFM_IIR_RDA 3'h2
`define UFM_IIR_THR 3'h1

`define UFM_TICKS_BIT 5'h10
`define UFM_TICKS_HALF 5'h08
`define UFM_TICKS_ONEHALF 5'h18
`define UFM_TICKS_TWO 6'h20

`endif

// *** ufm_pkg.sv ***
// Purpose: Types shared by the serial port core.
// Assumes: Nothing beyond the defines header.
// Notes: State codes are left to the tool.
package ufm_pkg;
    typedef enum logic [2:0] {UFM_IDLE, UFM_START, UFM_DATA, UFM_PAR, UFM_STOP} ufm_line_state_type;
endpackage

// *** ufm_uart_properties.sv ***
// Purpose: Port-level checker for the serial port core.
// Assumes: One clock domain; shadows follow completed register writes.
// Notes: Outputs lag a register change by one clock.
`timescale 1ns/1ps
module ufm_uart_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic serial_out,
    input wire logic terminal_ready_out_n,
    input wire logic send_request_out_n,
    input wire logic irq_oe_n_out
);
    logic [7:0] lcr_q;
    logic [4:0] mcr_q;
    logic fen_q;
    logic wdone;
    logic rdone;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // A transfer counts only at the edge where waitrequest is low.
    assign wdone = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    assign rdone = avs_read_in && !avs_waitrequest_out;
    // Shadow copies, so the checker needs no view inside the design.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lcr_q <= 8'h03;
            mcr_q <= 5'h00;
            fen_q <= 1'b0;
        end else if (wdone) begin
            if (avs_address_in[4:2] == 3'h3) lcr_q <= avs_writedata_in[7:0];
            if (avs_address_in[4:2] == 3'h4) mcr_q <= avs_writedata_in[4:0];
            if (avs_address_in[4:2] == 3'h2) fen_q <= avs_writedata_in[0];
        end
    end
    property p_break_low;
        lcr_q[6] && $past(lcr_q[6]) |-> !serial_out;
    endproperty
    a_break_low: assert property (p_break_low)
        else $error("serial output high during break");
    property p_loop_mark;
        $stable(lcr_q[6]) && $stable(mcr_q[4]) && mcr_q[4] && !lcr_q[6] |-> serial_out;
    endproperty
    a_loop_mark: assert property (p_loop_mark)
        else $error("serial output not at mark in loopback");
    property p_dtr;
        $stable(mcr_q) |-> terminal_ready_out_n == !(mcr_q[0] && !mcr_q[4]);
    endproperty
    a_dtr: assert property (p_dtr)
        else $error("terminal ready pin wrong");
    property p_rts;
        $stable(mcr_q) |-> send_request_out_n == !(mcr_q[1] && !mcr_q[4]);
    endproperty
    a_rts: assert property (p_rts)
        else $error("send request pin wrong");
    property p_irq_oe;
        $stable(mcr_q) |-> irq_oe_n_out == !(mcr_q[3] && !mcr_q[4]);
    endproperty
    a_irq_oe: assert property (p_irq_oe)
        else $error("interrupt enable pin wrong");
    property p_mcr_read;
        rdone && avs_address_in[4:2] == 3'h4 |-> avs_readdata_out == {27'h0, mcr_q};
    endproperty
    a_mcr_read: assert property (p_mcr_read)
        else $error("modem control readback wrong");
    property p_iir_read;
        rdone && avs_address_in[4:2] == 3'h2 |-> avs_readdata_out[7:4] == {fen_q, fen_q, 2'b00};
    endproperty
    a_iir_read: assert property (p_iir_read)
        else $error("fifo enabled bits wrong");
    property p_lcr_read;
        rdone && avs_address_in[4:2] == 3'h3 |-> avs_readdata_out == {24'h0, lcr_q};
    endproperty
    a_lcr_read: assert property (p_lcr_read)
        else $error("line control readback wrong");
endmodule
bind ufm_uart ufm_uart_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .serial_out(serial_out),
    .terminal_ready_out_n(terminal_ready_out_n), .send_request_out_n(send_request_out_n),
    .irq_oe_n_out(irq_oe_n_out));

// *** ufm_line_peer.sv ***
// Purpose: Serial peripheral that sends characters and drives modem lines.
// Assumes: Divisor 1, so one bit lasts 16 clocks.
// Notes: Errors are injected only when the caller asks.
`timescale 1ns/1ps
module ufm_line_peer (
    input wire logic clk_in,
    output logic line_out,
    output logic cts_n_out,
    output logic dsr_n_out,
    output logic ri_n_out,
    output logic dcd_n_out
);
    logic line_q = 1'b1;
    logic [3:0] modem_q = 4'hF;
    // The line idles at mark between frames.
    assign line_out = line_q;
    assign {dcd_n_out, ri_n_out, dsr_n_out, cts_n_out} = modem_q;
    task automatic bit_out(input logic b);
        @(posedge clk_in);
        line_q <= b;
        repeat (15) @(posedge clk_in);
    endtask
    // One frame, least significant bit first; a single stop bit suffices.
    task automatic send(input logic [7:0] d, input int nbits, input logic pen, input logic pval,
                        input logic stop);
        bit_out(1'b0);
        for (int i = 0; i < nbits; i++) bit_out(d[i]);
        if (pen) bit_out(pval);
        bit_out(stop);
        @(posedge clk_in);
        line_q <= 1'b1;
    endtask
endmodule

// *** tb.sv ***
// Purpose: Register-level tests of the serial port core.
// Assumes: One wait state per access; divisor left at 1.
// Notes: Loopback covers transmit, the peer covers receive errors.
`timescale 1ns/1ps
module tb;
    import ufm_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] avs_address_in = 5'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out, serial_in, serial_out, cts_n, dsr_n, ri_n, dcd_n;
    logic terminal_ready_out_n, send_request_out_n, irq_out, irq_oe_n_out;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] rdv = 8'h00;
    logic [7:0] lcr_t [5] = '{8'h1B, 8'h0B, 8'h3B, 8'h3B, 8'h03};
    logic par_t [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic stop_t [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] lsr_t [5] = '{8'h65, 8'h61, 8'h61, 8'h65, 8'h69};
    always #5 clk_in = ~clk_in;
    ufm_uart u_dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'h1),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .serial_in(serial_in),
        .serial_out(serial_out), .clear_to_send_in_n(cts_n), .set_ready_in_n(dsr_n), .ring_in_n(ri_n),
        .carrier_in_n(dcd_n), .terminal_ready_out_n(terminal_ready_out_n), .send_request_out_n(send_request_out_n),
        .irq_out(irq_out), .irq_oe_n_out(irq_oe_n_out));
    ufm_line_peer u_peer (.clk_in(clk_in), .line_out(serial_in), .cts_n_out(cts_n), .dsr_n_out(dsr_n),
        .ri_n_out(ri_n), .dcd_n_out(dcd_n));
    task end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low; a hang is left to the cycle ceiling.
    task bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
        @(posedge clk_in);
        avs_address_in <= {idx, 2'b00};
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_writedata_in <= {24'h0, wd};
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
        rdv = avs_readdata_out[7:0];
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task wr(input logic [2:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task rd_chk(input logic [2:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rdv, exp);
    endtask
    task pins(input logic [7:0] exp);
        repeat (2) @(posedge clk_in);
        chk({5'h0, terminal_ready_out_n, send_request_out_n, irq_oe_n_out}, exp);
    endtask
    task irq_is(input logic exp);
        repeat (4) @(posedge clk_in);
        chk({7'h0, irq_out}, {7'h0, exp});
    endtask
    // Polling status is bounded so a silent receiver cannot stall the run.
    task wait_dr;
        rdv = 8'h00;
        for (int n = 0; n < 200 && rdv[0] !== 1'b1; n++) bus(1'b0, 3'h5, 8'h00);
    endtask
    // The cycle ceiling turns a hang into a failure.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            end_sim;
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk(3'h3, 8'h03);
        rd_chk(3'h2, 8'h01);
        wr(3'h2, 8'hF9);
        rd_chk(3'h2, 8'hC1);
        wr(3'h2, 8'h00);
        rd_chk(3'h2, 8'h01);
        wr(3'h4, 8'hEF);
        rd_chk(3'h4, 8'h0F);
        pins(8'h00);
        wr(3'h4, 8'h04);
        pins(8'h07);
        u_peer.modem_q <= 4'h0;
        bus(1'b0, 3'h6, 8'h00);
        wr(3'h4, 8'h1B);
        pins(8'h07);
        bus(1'b0, 3'h6, 8'h00);
        chk(rdv & 8'hF0, 8'hB0);
        for (int i = 0; i < 4; i++) begin
            wr(3'h3, 8'(i));
            wr(3'h0, 8'hA5);
            wait_dr;
            rd_chk(3'h0, 8'hA5 & (8'hFF >> (3 - i)));
            rd_chk(3'h5, 8'h60);
        end
        wr(3'h3, 8'h43);
        repeat (2) @(posedge clk_in);
        chk({7'h0, serial_out}, 8'h00);
        wr(3'h3, 8'h83);
        rd_chk(3'h0, 8'h01);
        wr(3'h3, 8'h03);
        chk({7'h0, serial_out}, 8'h01);
        wr(3'h1, 8'h04);
        rd_chk(3'h1, 8'h04);
        wr(3'h4, 8'h08);
        for (int i = 0; i < 5; i++) begin
            wr(3'h3, lcr_t[i]);
            u_peer.send(8'h01, 8, lcr_t[i][3], par_t[i], stop_t[i]);
            irq_is(lsr_t[i][2] | lsr_t[i][3]);
            rd_chk(3'h5, lsr_t[i]);
            rd_chk(3'h0, 8'h01);
            rd_chk(3'h5, 8'h60);
        end
        u_peer.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
        u_peer.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
        rd_chk(3'h5, 8'h63);
        rd_chk(3'h0, 8'h22);
        wr(3'h2, 8'h41);
        wr(3'h1, 8'h01);
        for (int i = 0; i < 3; i++) u_peer.send(8'(i), 8, 1'b0, 1'b0, 1'b1);
        irq_is(1'b0);
        u_peer.send(8'h33, 8, 1'b0, 1'b0, 1'b1);
        irq_is(1'b1);
        wr(3'h2, 8'h43);
        rd_chk(3'h5, 8'h60);
        rd_chk(3'h2, 8'hC1);
        u_peer.send(8'h44, 8, 1'b0, 1'b0, 1'b1);
        wr(3'h2, 8'h00);
        rd_chk(3'h5, 8'h60);
        end_sim;
    end
endmodule
